// file: src/motor_fault_consts.svh
// Timing and field constants for the motor fault supervisor.
// Operation
// RULE1: Estimator mode flags stall when estimated mechanical constant exceeds its threshold.
// RULE2: Startup mode samples phase advance at ramp end; stall if above threshold.
// RULE3: A stall stops commutation and releases all gates so the motor coasts.
// RULE4: After a stall, wait a 5 or 10 second hold-off, by select bit.
// RULE5: Stall hold-skip set means restart after stall with no hold-off.
// RULE6: Retry limit 3, 5, 10 or unlimited; past limit hold until zero demand.
// RULE7: Zero demand clears the stall retry counter.
// RULE8: Overcurrent has top priority and acts at once.
// RULE9: Check each commanded-on MOSFET comparator; on excess turn off all gates.
// RULE10: Recovery select 0 waits zero demand; 1 restarts automatically after 5 seconds.
// RULE11: Overcurrent hold-skip set means restart after overcurrent with no hold-off.
// RULE12: Ignore overcurrent comparator for a selectable blanking time after each turn-on.
// RULE13: Comparator must persist a selectable filter time while gate is on.
// RULE14: Trip level field is driven out to the analog comparator.
// RULE15: Charge-pump or regulator undervoltage disables outputs until the flag clears.
// RULE16: Fault indication is asserted while undervoltage is active.
// RULE17: Enabled overvoltage stops control and coasts; restart once the flag clears.
// RULE18: Disabled overvoltage neither stops the motor nor raises the fault indication.
// RULE19: Zero-demand flag follows the transformed demand when the transformer is active.
// RULE20: Zero-demand flag is indication only and clears on nonzero demand.
// RULE21: Overtemperature stops and coasts; restart after clearing only with nonzero demand.
// RULE22: Second-scale hold-offs come from the core clock through a prescaler.
`ifndef MOTOR_FAULT_CONSTS_SVH
`define MOTOR_FAULT_CONSTS_SVH
`define CLOCK_HZ 50000000
`define PRESCALE_CYCLES (`CLOCK_HZ / 10)
`define PRESCALE_W 23
`define HOLD_5S_SEC 5
`define HOLD_10S_SEC 10
`define TICKS_PER_SEC 10
`define HOLD_W 7
`define HOLD_5S_TICKS 7'h32
`define HOLD_10S_TICKS 7'h64
`define RETRY_W 4
`define RETRY_3 4'h3
`define RETRY_5 4'h5
`define RETRY_10 4'hA
`define FILT_W 6
`define BLANK_CYCLES_0 6'h08
`define BLANK_CYCLES_1 6'h10
`define BLANK_CYCLES_2 6'h20
`define BLANK_CYCLES_3 6'h3F
`define FILT_CYCLES_0 6'h02
`define FILT_CYCLES_1 6'h04
`define FILT_CYCLES_2 6'h08
`define FILT_CYCLES_3 6'h10
`define FILT_SATURATE 6'h3F
`define DEMAND_W 9
`define DEMAND_ZERO 9'h000
`endif

// file: src/motor_fault_pkg.sv
// Types shared by the motor fault supervisor.
package motor_fault_pkg;
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_STALL_HOLD = 5'h02,
		ST_STALL_LOCK = 5'h04,
		ST_OC_HOLD = 5'h08,
		ST_OC_LOCK = 5'h10
	} fault_state_t;

	typedef struct packed {
		logic stall_holdoff_skip;
		logic stall_hold_long;
		logic [1:0] stall_retry_select;
		logic overcurrent_recovery_select;
		logic overcurrent_holdoff_skip;
		logic [1:0] vds_blanking_select;
		logic [1:0] vds_filter_select;
		logic [1:0] vds_trip_level_select;
		logic supply_overvolt_protect_enable;
		logic estimator_stall_enable;
	} fault_config_t;

	typedef struct packed {
		fault_state_t state;
		logic [22:0] prescale;
		logic [6:0] hold;
		logic [3:0] retries;
		logic [5:0][5:0] blank;
		logic [5:0][5:0] filt;
		logic [5:0] gate_prev;
		logic gate_disable;
		logic coast;
		logic restart_request;
		logic fault_indication;
		logic zero_demand_flag;
		logic thermal_latched;
	} fault_regs_t;
endpackage : motor_fault_pkg

// file: src/motor_fault_supervisor.sv
// Fault supervision for a sensorless motor gate driver: stall, overcurrent, undervoltage, overvoltage, thermal.
`timescale 1ns/1ps
`include "motor_fault_consts.svh"
module motor_fault_supervisor (
	input wire logic clock,
	input wire logic rst,
	input wire motor_fault_pkg::fault_config_t config_in,
	input wire logic estimate_above_threshold,
	input wire logic ramp_end,
	input wire logic phase_advance_above_threshold,
	input wire logic [5:0] gate_command,
	input wire logic [5:0] vds_compare,
	input wire logic charge_pump_undervolt,
	input wire logic regulator_undervolt,
	input wire logic supply_overvolt,
	input wire logic thermal_shutdown,
	input wire logic transformer_active,
	input wire logic [8:0] raw_demand,
	input wire logic [8:0] transformed_demand,
	output logic gate_disable,
	output logic coast,
	output logic restart_request,
	output logic fault_indication,
	output logic zero_demand_flag,
	output logic overcurrent_fault,
	output logic stall_fault,
	output logic [1:0] vds_trip_level
);
	motor_fault_pkg::fault_regs_t r;
	motor_fault_pkg::fault_regs_t next_r;
	logic [8:0] demand;
	logic demand_zero;
	logic stall_event;
	logic overcurrent_event;
	logic tick;
	logic undervolt;
	logic overvolt_stop;
	logic [5:0] trip;

	////////////////////////////////////////////////////////////////////////////
	// Blanking length in cycles for the select code; long enough to pass the Miller plateau.
	function automatic logic [5:0] blank_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: blank_cycles = `BLANK_CYCLES_0;
			2'h1: blank_cycles = `BLANK_CYCLES_1;
			2'h2: blank_cycles = `BLANK_CYCLES_2;
			default: blank_cycles = `BLANK_CYCLES_3;
		endcase
	endfunction : blank_cycles

	// Filter length in cycles the comparator must persist.
	function automatic logic [5:0] filter_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: filter_cycles = `FILT_CYCLES_0;
			2'h1: filter_cycles = `FILT_CYCLES_1;
			2'h2: filter_cycles = `FILT_CYCLES_2;
			default: filter_cycles = `FILT_CYCLES_3;
		endcase
	endfunction : filter_cycles

	// Retry limit; zero means unlimited.
	function automatic logic [3:0] retry_limit(input logic [1:0] sel);
		case (sel)
			2'h0: retry_limit = `RETRY_3;
			2'h1: retry_limit = `RETRY_5;
			2'h2: retry_limit = `RETRY_10;
			default: retry_limit = 4'h0;
		endcase
	endfunction : retry_limit

	////////////////////////////////////////////////////////////////////////////
	// Demand decode and fault detection terms.
	assign demand = transformer_active ? transformed_demand : raw_demand; // see RULE19
	assign demand_zero = (demand == `DEMAND_ZERO);
	assign tick = (r.prescale == 23'(`PRESCALE_CYCLES - 1)); // see RULE22
	assign stall_event = (config_in.estimator_stall_enable & estimate_above_threshold) // see RULE1
		| (~config_in.estimator_stall_enable & ramp_end & phase_advance_above_threshold); // see RULE2
	assign undervolt = charge_pump_undervolt | regulator_undervolt;
	assign overvolt_stop = config_in.supply_overvolt_protect_enable & supply_overvolt; // see RULE17 see RULE18
	assign vds_trip_level = config_in.vds_trip_level_select; // see RULE14
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			// The cycle in which a gate turns on is blanked too, before the counter has loaded.
			trip[i] = gate_command[i] && r.gate_prev[i] && (r.blank[i] == 6'h00)
				&& (r.filt[i] >= filter_cycles(config_in.vds_filter_select)); // see RULE9 see RULE13
		end
	end
	assign overcurrent_event = |trip;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic for the whole supervisor.
	always_comb
	begin
		next_r = r;
		next_r.restart_request = 1'b0;
		next_r.gate_prev = gate_command;
		next_r.prescale = tick ? 23'h000000 : r.prescale + 23'h000001;
		for (int i = 0; i < 6; i++)
		begin
			// Blanking restarts on every rising gate command.
			if (gate_command[i] && !r.gate_prev[i])
			begin
				next_r.blank[i] = blank_cycles(config_in.vds_blanking_select); // see RULE12
			end
			else if (r.blank[i] != 6'h00)
			begin
				next_r.blank[i] = r.blank[i] - 6'h01;
			end
			// Persistence counter saturates so the compare stays valid.
			if (gate_command[i] && r.gate_prev[i] && r.blank[i] == 6'h00 && vds_compare[i])
			begin
				next_r.filt[i] = (r.filt[i] == `FILT_SATURATE) ? r.filt[i] : r.filt[i] + 6'h01; // see RULE13
			end
			else
			begin
				next_r.filt[i] = 6'h00;
			end
		end
		next_r.zero_demand_flag = demand_zero; // see RULE20
		if (thermal_shutdown)
		begin
			next_r.thermal_latched = 1'b1;
		end
		else if (r.thermal_latched && !demand_zero)
		begin
			next_r.thermal_latched = 1'b0; // see RULE21
			next_r.restart_request = 1'b1;
		end
		if (tick && r.hold != 7'h00)
		begin
			next_r.hold = r.hold - 7'h01;
		end
		// Overcurrent is checked first so no other fault can delay it.
		if (overcurrent_event)
		begin
			next_r.state = motor_fault_pkg::ST_OC_LOCK; // see RULE8 see RULE9
			if (config_in.overcurrent_holdoff_skip)
			begin
				next_r.state = motor_fault_pkg::ST_OC_HOLD; // see RULE11
				next_r.hold = 7'h00;
			end
			else if (config_in.overcurrent_recovery_select)
			begin
				next_r.state = motor_fault_pkg::ST_OC_HOLD; // see RULE10
				next_r.hold = `HOLD_5S_TICKS;
			end
		end
		else
		begin
			case (r.state)
				motor_fault_pkg::ST_RUN:
				begin
					if (stall_event)
					begin
						next_r.retries = r.retries + 4'h1;
						if (retry_limit(config_in.stall_retry_select) != 4'h0
							&& r.retries >= retry_limit(config_in.stall_retry_select))
						begin
							next_r.state = motor_fault_pkg::ST_STALL_LOCK; // see RULE6
						end
						else
						begin
							next_r.state = motor_fault_pkg::ST_STALL_HOLD; // see RULE3
							next_r.hold = config_in.stall_holdoff_skip ? 7'h00 // see RULE5
								: (config_in.stall_hold_long ? `HOLD_10S_TICKS : `HOLD_5S_TICKS); // see RULE4
						end
					end
				end
				motor_fault_pkg::ST_STALL_HOLD, motor_fault_pkg::ST_OC_HOLD:
				begin
					if (r.hold == 7'h00)
					begin
						next_r.state = motor_fault_pkg::ST_RUN;
						next_r.restart_request = 1'b1;
					end
				end
				motor_fault_pkg::ST_STALL_LOCK, motor_fault_pkg::ST_OC_LOCK:
				begin
					if (demand_zero)
					begin
						next_r.state = motor_fault_pkg::ST_RUN; // see RULE6 see RULE10
						next_r.restart_request = 1'b1;
					end
				end
				default:
				begin
					next_r.state = motor_fault_pkg::ST_RUN;
				end
			endcase
		end
		// Zero demand clears the retry count last, so a stall in the same cycle cannot undo it.
		if (demand_zero)
		begin
			next_r.retries = 4'h0; // see RULE7
		end
		// Gates off in any fault; undervolt holds them off regardless of state.
		next_r.gate_disable = overcurrent_event || undervolt || overvolt_stop || next_r.thermal_latched
			|| next_r.state != motor_fault_pkg::ST_RUN; // see RULE15
		next_r.coast = next_r.gate_disable;
		next_r.fault_indication = undervolt || overvolt_stop || next_r.state != motor_fault_pkg::ST_RUN; // see RULE16
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			r <= '{state: motor_fault_pkg::ST_RUN, default: '0};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign gate_disable = r.gate_disable;
	assign coast = r.coast;
	assign restart_request = r.restart_request;
	assign fault_indication = r.fault_indication;
	assign zero_demand_flag = r.zero_demand_flag;
	assign overcurrent_fault = (r.state == motor_fault_pkg::ST_OC_HOLD) || (r.state == motor_fault_pkg::ST_OC_LOCK);
	assign stall_fault = (r.state == motor_fault_pkg::ST_STALL_HOLD) || (r.state == motor_fault_pkg::ST_STALL_LOCK);

	////////////////////////////////////////////////////////////////////////////
	// Checks on the supervisor behaviour.
	// An overcurrent trip must reach the gates on the very next edge.
	a_oc_gates_off: assert property (@(posedge clock) disable iff (rst) // see RULE9
		overcurrent_event
		|=> gate_disable && overcurrent_fault)
		else $error("overcurrent did not disable gates");

	// Undervolt is level driven, so gates stay off for as long as it lasts.
	a_uv_holds_off: assert property (@(posedge clock) disable iff (rst) // see RULE15
		undervolt
		|=> gate_disable && fault_indication)
		else $error("undervolt did not hold gates off");

	// Only the overvoltage itself may be present here; every other fault source is excluded.
	a_ov_ignored: assert property (@(posedge clock) disable iff (rst) // see RULE18
		supply_overvolt && !config_in.supply_overvolt_protect_enable && r.state == motor_fault_pkg::ST_RUN
		&& !undervolt && !thermal_shutdown && !r.thermal_latched && !overcurrent_event && !stall_event
		|=> !fault_indication)
		else $error("disabled overvolt raised fault");

	// The zero flag follows whichever demand is selected.
	a_zero_flag: assert property (@(posedge clock) disable iff (rst) // see RULE19
		demand_zero
		|=> zero_demand_flag)
		else $error("zero demand flag missing");

	// A stall in the run state must release the gates at once.
	a_stall_coasts: assert property (@(posedge clock) disable iff (rst) // see RULE3
		r.state == motor_fault_pkg::ST_RUN && stall_event && !overcurrent_event
		|=> stall_fault && coast)
		else $error("stall did not coast");

	// No trip may come from transistor 0 while still inside its blanking time.
	a_blank_masks: assert property (@(posedge clock) disable iff (rst) // see RULE12
		r.blank[0] != 6'h00
		|-> !trip[0])
		else $error("trip inside blanking");

	// Zero demand always wins over a stall counted in the same cycle.
	a_retry_clear: assert property (@(posedge clock) disable iff (rst) // see RULE7
		demand_zero
		|=> r.retries == 4'h0)
		else $error("retry count not cleared");

	// The analog comparator must see the selected level at all times.
	a_trip_level: assert property (@(posedge clock) disable iff (rst) // see RULE14
		1'b1
		|-> vds_trip_level == config_in.vds_trip_level_select)
		else $error("trip level not driven");

	// A locked stall must not restart by itself while demand stays nonzero.
	a_lock_holds: assert property (@(posedge clock) disable iff (rst) // see RULE6
		r.state == motor_fault_pkg::ST_STALL_LOCK && !demand_zero && !overcurrent_event
		|=> stall_fault)
		else $error("stall lock released early");

	// Zero demand is the only way out of the stall lock other than an overcurrent trip.
	a_lock_release: assert property (@(posedge clock) disable iff (rst) // see RULE6
		r.state == motor_fault_pkg::ST_STALL_LOCK && demand_zero && !overcurrent_event
		|=> !stall_fault && restart_request)
		else $error("stall lock not released by zero demand");

	// The flag is indication only and must drop with the first nonzero demand.
	a_zero_clears: assert property (@(posedge clock) disable iff (rst) // see RULE20
		!demand_zero
		|=> !zero_demand_flag)
		else $error("zero demand flag stuck");

	// An enabled supply overvoltage stops control and shows on the fault output.
	a_ov_coasts: assert property (@(posedge clock) disable iff (rst) // see RULE17
		overvolt_stop
		|=> coast && fault_indication)
		else $error("enabled overvolt did not coast");

	// Overtemperature coasts the motor on the next edge.
	a_hot_coasts: assert property (@(posedge clock) disable iff (rst) // see RULE21
		thermal_shutdown
		|=> coast)
		else $error("overtemperature did not coast");

	// A cooled part with zero demand must keep waiting rather than restart.
	a_hot_waits: assert property (@(posedge clock) disable iff (rst) // see RULE21
		r.thermal_latched && !thermal_shutdown && demand_zero
		|=> coast)
		else $error("thermal restart without demand");

	// The overcurrent lock is left through zero demand, or through a new overcurrent trip into ST_OC_HOLD when hold-skip or recovery select is set.
	a_oc_lock_waits: assert property (@(posedge clock) disable iff (rst) // see RULE10
		r.state == motor_fault_pkg::ST_OC_LOCK && !demand_zero
		|=> overcurrent_fault)
		else $error("overcurrent lock released early");

	// An expired or skipped hold-off must restart on the next edge.
	a_skip_restart: assert property (@(posedge clock) disable iff (rst) // see RULE5
		(r.state == motor_fault_pkg::ST_STALL_HOLD || r.state == motor_fault_pkg::ST_OC_HOLD)
		&& r.hold == 7'h00 && !overcurrent_event
		|=> restart_request)
		else $error("hold-off expiry did not restart");

	// While hold-off ticks remain the stall must stand.
	a_hold_counts: assert property (@(posedge clock) disable iff (rst) // see RULE4
		r.state == motor_fault_pkg::ST_STALL_HOLD && r.hold != 7'h00 && !overcurrent_event
		|=> stall_fault)
		else $error("stall hold-off cut short");

	// The prescaler wraps to zero after each tick, so ticks are evenly spaced.
	a_tick_period: assert property (@(posedge clock) disable iff (rst) // see RULE22
		tick
		|=> r.prescale == 23'h000000)
		else $error("prescaler did not wrap");

	// Every turn-on of gate 0 loads a nonzero blanking count.
	a_blank_load: assert property (@(posedge clock) disable iff (rst) // see RULE12
		gate_command[0] && !r.gate_prev[0]
		|=> r.blank[0] != 6'h00)
		else $error("blanking not loaded on turn-on");

	// Main scenarios that the bench is expected to reach.
	c_overcurrent: cover property (@(posedge clock) overcurrent_event);
	c_stall_restart: cover property (@(posedge clock) stall_fault ##1 restart_request);
	c_stall_lock: cover property (@(posedge clock) r.state == motor_fault_pkg::ST_STALL_LOCK);
	c_undervolt: cover property (@(posedge clock) undervolt ##1 fault_indication);
	c_thermal_restart: cover property (@(posedge clock) r.thermal_latched ##1 restart_request);
endmodule : motor_fault_supervisor

// file: testbench/mosfet_bridge_model.sv
// Behavioural model of the external MOSFET bridge and its drain-source comparators.
`timescale 1ns/1ps
module mosfet_bridge_model (
	input wire logic [5:0] gate_command,
	input wire logic short_circuit,
	output logic [5:0] vds_compare
);
	// A shorted load only shows excess drain-source voltage on a transistor that conducts.
	always_comb
	begin
		vds_compare = gate_command & {6{short_circuit}};
	end
endmodule : mosfet_bridge_model

// file: testbench/motor_fault_supervisor_test.sv
// Self-checking testbench for the motor fault supervisor.
`timescale 1ns/1ps
module motor_fault_supervisor_test;
	logic clock = 1'b0;
	logic rst = 1'b1;
	motor_fault_pkg::fault_config_t cfg = '0;
	logic est = 1'b0, ramp = 1'b0, adv = 1'b0, cp_uv = 1'b0, reg_uv = 1'b0, ovp = 1'b0, hot = 1'b0;
	logic xf = 1'b0, shorted = 1'b0;
	logic [5:0] gates = 6'h00, vds;
	logic [8:0] raw = 9'h010, xdem = 9'h010;
	logic gate_disable, coast, restart_request, fault_indication, zero_demand_flag, overcurrent_fault, stall_fault;
	logic [1:0] vds_trip_level;
	int errors = 0;
	int samples_checked = 0;
	//////////////////////////////////////////////////////////////////////////////
	// The clock toggles every half period of 10 ns.
	always #10 clock = ~clock;
	motor_fault_supervisor motor_fault_supervisor_i (.clock(clock), .rst(rst), .config_in(cfg),
		.estimate_above_threshold(est), .ramp_end(ramp), .phase_advance_above_threshold(adv),
		.gate_command(gates), .vds_compare(vds), .charge_pump_undervolt(cp_uv), .regulator_undervolt(reg_uv),
		.supply_overvolt(ovp), .thermal_shutdown(hot), .transformer_active(xf), .raw_demand(raw),
		.transformed_demand(xdem), .gate_disable(gate_disable), .coast(coast), .restart_request(restart_request),
		.fault_indication(fault_indication), .zero_demand_flag(zero_demand_flag),
		.overcurrent_fault(overcurrent_fault), .stall_fault(stall_fault), .vds_trip_level(vds_trip_level));
	mosfet_bridge_model mosfet_bridge_model_i (.gate_command(gates), .short_circuit(shorted), .vds_compare(vds));
	//////////////////////////////////////////////////////////////////////////////
	// Inputs move 1 ns or more after the rising edge so no race with the design's sampling.
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task check(input string name, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	// Waits a bounded number of cycles; a slow design simply reports not seen.
	task wait_for(input int sel, input int lim, output logic seen);
		seen = 1'b0;
		repeat (lim)
		begin
			step(1);
			case (sel)
				0: seen = seen | (overcurrent_fault === 1'b1);
				1: seen = seen | (restart_request === 1'b1);
				2: seen = seen | (stall_fault === 1'b1);
				default: seen = seen | (coast === 1'b1);
			endcase
		end
	endtask : wait_for
	task end_of_test;
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	//////////////////////////////////////////////////////////////////////////////
	task t_overcurrent(input logic skip);
		logic seen;
		cfg.overcurrent_holdoff_skip = skip;
		shorted = 1'b1;
		wait_for(0, 30, seen);
		check("oc_gate_off", 1'b0, seen);
		gates = 6'h01;
		wait_for(0, 5, seen);
		check("oc_blank", 1'b0, seen);
		wait_for(0, 20, seen);
		check("oc_trip", 1'b1, seen);
		check("oc_disable", 1'b1, gate_disable);
		gates = 6'h00;
		shorted = 1'b0;
		if (!skip)
		begin
			wait_for(1, 20, seen);
			check("oc_waits_demand", 1'b0, seen);
			raw = 9'h000;
		end
		wait_for(1, 10, seen);
		check("oc_restart", 1'b1, seen);
		raw = 9'h010;
		step(3);
	endtask : t_overcurrent
	task t_supply;
		cp_uv = 1'b1;
		step(2);
		check("uv_disable", 1'b1, gate_disable);
		check("uv_fault", 1'b1, fault_indication);
		cp_uv = 1'b0;
		reg_uv = 1'b1;
		step(2);
		check("uv_reg_disable", 1'b1, gate_disable);
		reg_uv = 1'b0;
		step(2);
		check("uv_release", 1'b0, gate_disable);
		ovp = 1'b1;
		step(3);
		check("ovp_off_coast", 1'b0, coast);
		check("ovp_off_fault", 1'b0, fault_indication);
		cfg.supply_overvolt_protect_enable = 1'b1;
		step(3);
		check("ovp_coast", 1'b1, coast);
		ovp = 1'b0;
		step(3);
		check("ovp_release", 1'b0, coast);
	endtask : t_supply
	task t_demand;
		logic seen;
		xf = 1'b1;
		xdem = 9'h000;
		step(2);
		check("zero_flag", 1'b1, zero_demand_flag);
		check("zero_no_action", 1'b0, gate_disable);
		xdem = 9'h001;
		step(2);
		check("zero_clear", 1'b0, zero_demand_flag);
		hot = 1'b1;
		step(3);
		check("hot_coast", 1'b1, coast);
		xdem = 9'h000;
		hot = 1'b0;
		wait_for(1, 10, seen);
		check("hot_no_demand", 1'b0, seen);
		xdem = 9'h020;
		wait_for(1, 10, seen);
		check("hot_restart", 1'b1, seen);
		xf = 1'b0;
		step(3);
	endtask : t_demand
	task t_stall;
		logic seen;
		int k;
		cfg.stall_holdoff_skip = 1'b1;
		cfg.estimator_stall_enable = 1'b1;
		est = 1'b1;
		wait_for(2, 5, seen);
		est = 1'b0;
		check("stall_est", 1'b1, seen);
		wait_for(1, 10, seen);
		check("stall_restart", 1'b1, seen);
		step(3);
		cfg.estimator_stall_enable = 1'b0;
		adv = 1'b1;
		ramp = 1'b1;
		step(1);
		ramp = 1'b0;
		wait_for(3, 4, seen);
		check("stall_ramp", 1'b1, seen);
		adv = 1'b0;
		step(10);
		wait_for(1, 20, seen);
		check("stall_lock_holds", 1'b0, seen);
		raw = 9'h000;
		wait_for(1, 3, seen);
		check("stall_lock_release", 1'b1, seen);
		raw = 9'h010;
		cfg.stall_holdoff_skip = 1'b0;
		cfg.estimator_stall_enable = 1'b1;
		est = 1'b1;
		step(1);
		est = 1'b0;
		wait_for(1, 20, seen);
		check("stall_holdoff", 1'b0, seen);
		check("stall_held", 1'b1, stall_fault);
		for (k = 0; k < 4; k++)
		begin
			cfg.vds_trip_level_select = k[1:0];
			#1;
			check("trip_level_lo", k[0], vds_trip_level[0]);
			check("trip_level_hi", k[1], vds_trip_level[1]);
		end
	endtask : t_stall
	//////////////////////////////////////////////////////////////////////////////
	// Main sequence: five cycles of reset, then the scenarios in turn.
	initial
	begin
		step(5);
		rst = 1'b0;
		step(2);
		t_overcurrent(1'b0);
		t_overcurrent(1'b1);
		t_supply;
		t_demand;
		t_stall;
		end_of_test;
	end
	// The scenarios need well under a thousand cycles; a hang is cut off long after that.
	initial
	begin
		#200000;
		errors++;
		end_of_test;
	end
endmodule : motor_fault_supervisor_test
